/* hw/dsd_dimming.sv */
// Top of the two-string dimming logic: pin sync, duty codes, variant select, gate outputs.
`default_nettype none

module dsd_dimming
    import dsd_pkg::*;
#(
    parameter bit PIN_VARIANT  = 1'b0,
    parameter int PERIOD_CYC   = DIM_PERIOD_CYC,
    parameter int MIN_ON_CYC   = MAIN_MIN_ON_CYC
) (
    input  wire logic       core_clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       enable_in,
    input  wire logic       main_dim_in,
    input  wire logic       color_dim_in,
    input  wire logic       duty_wr_in,
    input  wire logic [1:0] duty_sel_in,
    input  wire logic [7:0] duty_data_in,
    output logic            main_gate_out,
    output logic            color_gate_out,
    output logic            running_out
);

    localparam int MW = $clog2(MIN_ON_CYC + 1);
    localparam logic [MW-1:0] MIN_LOAD_V = MW'(MIN_ON_CYC - 1);

    // Refuse settings the counters cannot serve.
    if (PERIOD_CYC < 4) begin : g_bad_period
        $error("dsd_dimming: dimming period too short");
    end
    if (MIN_ON_CYC < 1) begin : g_bad_min_on
        $error("dsd_dimming: least on-time must be at least one cycle");
    end

    // Merges one written byte into a duty code; used for both strings.
    function automatic logic [DUTY_W-1:0] dsd_merge(
        input logic [DUTY_W-1:0] code,
        input logic              hi,
        input logic              lo,
        input logic [7:0]        data
    );
        logic [DUTY_W-1:0] r;
        r = code;
        if (hi) begin
            r[DUTY_W-1:DUTY_HI_LSB] = data;
        end
        if (lo) begin
            r[DUTY_LO_W-1:0] = data[DUTY_LO_W-1:0];
        end
        return r;
    endfunction

    // Pin synchronisers: stage one is read only by stage two.
    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;
    logic [2:0] pin_s1_d;
    logic [2:0] pin_s2_d;

    always_comb begin
        pin_s1_d = {enable_in, color_dim_in, main_dim_in};
        pin_s2_d = pin_s1_q;
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
        end else begin
            pin_s1_q <= pin_s1_d;
            pin_s2_q <= pin_s2_d;
        end
    end

    logic main_pin;
    logic color_pin;
    logic en_pin;

    assign main_pin  = pin_s2_q[0];
    assign color_pin = pin_s2_q[1];
    assign en_pin    = pin_s2_q[2];

    // Run state follows the synchronised enable; its rising edge restarts everything.
    dsd_run_e run_q;
    dsd_run_e run_d;
    logic     en_rise;

    always_comb begin
        en_rise = en_pin & (run_q == DSD_OFF);
        unique case (run_q)
            DSD_OFF: run_d = en_pin ? DSD_RUN : DSD_OFF;
            DSD_RUN: run_d = en_pin ? DSD_RUN : DSD_OFF;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            run_q <= DSD_OFF;
        end else begin
            run_q <= run_d;
        end
    end

    // Pending duty codes; the channels pick them up at their period boundary.
    logic [DUTY_W-1:0] main_code_q;
    logic [DUTY_W-1:0] main_code_d;
    logic [DUTY_W-1:0] color_code_q;
    logic [DUTY_W-1:0] color_code_d;
    logic [DUTY_W-1:0] main_feed;
    logic [DUTY_W-1:0] color_feed;

    always_comb begin
        main_code_d  = main_code_q;
        color_code_d = color_code_q;
        if (en_rise) begin
            // A reload wins over a write in the same cycle, as a fresh start must.
            main_code_d  = MAIN_DUTY_RST;
            color_code_d = COLOR_DUTY_RST;
        end else if (duty_wr_in) begin
            main_code_d  = dsd_merge(main_code_q, duty_sel_in == SEL_MAIN_HI,
                                     duty_sel_in == SEL_MAIN_LO, duty_data_in);
            color_code_d = dsd_merge(color_code_q, duty_sel_in == SEL_COLOR_HI,
                                     duty_sel_in == SEL_COLOR_LO, duty_data_in);
        end
        // On restart the channels must see the stored values, not the stale pending codes.
        main_feed  = en_rise ? MAIN_DUTY_RST : main_code_q;
        color_feed = en_rise ? COLOR_DUTY_RST : color_code_q;
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            main_code_q  <= MAIN_DUTY_RST;
            color_code_q <= COLOR_DUTY_RST;
        end else begin
            main_code_q  <= main_code_d;
            color_code_q <= color_code_d;
        end
    end

    // Register-variant channels; the color one starts half a period in.
    logic main_reg_pwm;
    logic color_reg_pwm;

    dsd_pwm_chan #(
        .PERIOD_CYC (PERIOD_CYC),
        .START_CYC  (0),
        .CODE_RST   (MAIN_DUTY_RST)
    ) u_main_chan (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .run_in      (run_q == DSD_RUN),
        .restart_in  (en_rise),
        .code_in     (main_feed),
        .pwm_out     (main_reg_pwm)
    );

    dsd_pwm_chan #(
        .PERIOD_CYC (PERIOD_CYC),
        .START_CYC  (PERIOD_CYC / 2),
        .CODE_RST   (COLOR_DUTY_RST)
    ) u_color_chan (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .run_in      (run_q == DSD_RUN),
        .restart_in  (en_rise),
        .code_in     (color_feed),
        .pwm_out     (color_reg_pwm)
    );

    // Variant select: the pin variant has no timebase and simply follows the inputs.
    logic main_raw;
    logic color_raw;

    always_comb begin
        if (PIN_VARIANT) begin
            main_raw  = main_pin;
            color_raw = color_pin;
        end else begin
            main_raw  = main_reg_pwm;
            color_raw = color_reg_pwm;
        end
    end

    // Main gate pulse stretcher; a short input pulse lengthens duty slightly at high rates.
    logic          main_prev_q;
    logic          main_prev_d;
    logic [MW-1:0] min_cnt_q;
    logic [MW-1:0] min_cnt_d;
    logic          main_gate_q;
    logic          main_gate_d;
    logic          color_gate_q;
    logic          color_gate_d;
    logic          running_q;
    logic          running_d;
    logic          run_on;

    always_comb begin
        run_on      = (run_q == DSD_RUN);
        main_prev_d = main_raw & run_on;
        min_cnt_d   = min_cnt_q;
        if (!run_on) begin
            min_cnt_d = '0;
        end else if (main_raw && !main_prev_q) begin
            min_cnt_d = MIN_LOAD_V;
        end else if (min_cnt_q != '0) begin
            min_cnt_d = min_cnt_q - 1'b1;
        end
        main_gate_d  = run_on & (main_raw | (min_cnt_q != '0));
        color_gate_d = run_on & color_raw;
        running_d    = run_on;
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            main_prev_q  <= 1'b0;
            min_cnt_q    <= '0;
            main_gate_q  <= 1'b0;
            color_gate_q <= 1'b0;
            running_q    <= 1'b0;
        end else begin
            main_prev_q  <= main_prev_d;
            min_cnt_q    <= min_cnt_d;
            main_gate_q  <= main_gate_d;
            color_gate_q <= color_gate_d;
            running_q    <= running_d;
        end
    end

    // Outputs come straight from flops.
    assign main_gate_out  = main_gate_q;
    assign color_gate_out = color_gate_q;
    assign running_out    = running_q;

endmodule // dsd_dimming

`default_nettype wire

/* include/dsd_pkg.sv */
// Shared constants for the two-string dimming block.
`default_nettype none

package dsd_pkg;

    // Core clock rate and period.
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_PERIOD_NS = 50;

    // Fixed dimming rate of the register variant and its period in core cycles.
    localparam int DIM_RATE_HZ = 400;
    localparam int DIM_PERIOD_CYC = CLK_HZ / DIM_RATE_HZ;

    // Least on-time of the main gate; a least time rounds up to whole cycles.
    localparam int MAIN_MIN_ON_NS = 2000;
    localparam int MAIN_MIN_ON_CYC = (MAIN_MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Duty code layout: the high byte holds bits 11 to 4, the low nibble bits 3 to 0.
    localparam int DUTY_W = 12;
    localparam int DUTY_HI_LSB = 4;
    localparam int DUTY_LO_W = 4;
    localparam logic [DUTY_W-1:0] DUTY_FULL = 12'hFFF;

    // Stored power-up values of the duty codes.
    localparam logic [DUTY_W-1:0] MAIN_DUTY_RST = 12'hFFF;
    localparam logic [DUTY_W-1:0] COLOR_DUTY_RST = 12'hFFF;

    // Byte selects of the duty code write port.
    localparam logic [1:0] SEL_MAIN_HI = 2'h0;
    localparam logic [1:0] SEL_MAIN_LO = 2'h1;
    localparam logic [1:0] SEL_COLOR_HI = 2'h2;
    localparam logic [1:0] SEL_COLOR_LO = 2'h3;

    // Run state of the dimming logic, Gray coded.
    typedef enum logic {
        DSD_OFF = 1'b0,
        DSD_RUN = 1'b1
    } dsd_run_e;

endpackage : dsd_pkg

`default_nettype wire

/* hw/dsd_pwm_chan.sv */
// One register-variant dimming channel: period counter, code latch and compare.
`default_nettype none

module dsd_pwm_chan
    import dsd_pkg::*;
#(
    parameter int              PERIOD_CYC = DIM_PERIOD_CYC,
    parameter int              START_CYC  = 0,
    parameter logic [DUTY_W-1:0] CODE_RST = MAIN_DUTY_RST
) (
    input  wire logic              core_clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              run_in,
    input  wire logic              restart_in,
    input  wire logic [DUTY_W-1:0] code_in,
    output logic                   pwm_out
);

    localparam int CW = $clog2(PERIOD_CYC);
    localparam logic [CW-1:0] LAST_V = CW'(PERIOD_CYC - 1);
    localparam logic [CW-1:0] START_V = CW'(START_CYC);
    localparam logic [CW+DUTY_W-1:0] PERIOD_V = (CW + DUTY_W)'(PERIOD_CYC);

    logic [CW-1:0]        cnt_q;
    logic [CW-1:0]        cnt_d;
    logic [DUTY_W-1:0]    code_q;
    logic [DUTY_W-1:0]    code_d;
    logic                 pwm_q;
    logic                 pwm_d;
    logic [CW+DUTY_W-1:0] prod;
    logic [CW-1:0]        thr;

    if (START_CYC < 0 || START_CYC >= PERIOD_CYC) begin : g_bad_start
        $error("dsd_pwm_chan: start offset outside the period");
    end

    // The code is taken only at the period boundary or on restart so a pulse is never cut or doubled.
    always_comb begin
        cnt_d  = cnt_q;
        code_d = code_q;
        prod   = code_q * PERIOD_V;
        thr    = prod[CW+DUTY_W-1:DUTY_W];
        if (restart_in) begin
            cnt_d  = START_V;
            code_d = code_in;
        end else if (cnt_q == LAST_V) begin
            cnt_d  = '0;
            code_d = code_in;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
        // Full code keeps the string on; the scaled compare cannot reach the whole period.
        pwm_d = run_in & ((code_q == DUTY_FULL) | (cnt_q < thr));
    end

    // Channel state registers.
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            cnt_q  <= START_V;
            code_q <= CODE_RST;
            pwm_q  <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            code_q <= code_d;
            pwm_q  <= pwm_d;
        end
    end

    assign pwm_out = pwm_q;

endmodule // dsd_pwm_chan

`default_nettype wire

/* test/dsd_dim_assertions.sv */
// Port checker for the two-string dimming block in either build variant.
`default_nettype none
module dsd_dim_chk #(
    parameter bit PIN_VARIANT = 1'b0,
    parameter int PERIOD_CYC  = 200,
    parameter int MIN_ON_CYC  = 40
) (
    input wire logic       core_clk_in,
    input wire logic       rst_n_in,
    input wire logic       enable_in,
    input wire logic       main_dim_in,
    input wire logic       color_dim_in,
    input wire logic       duty_wr_in,
    input wire logic [1:0] duty_sel_in,
    input wire logic [7:0] duty_data_in,
    input wire logic       main_gate_out,
    input wire logic       color_gate_out,
    input wire logic       running_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    int   on_q    = 0;
    int   since_q = 0;
    logic vld_q   = 1'b0;
    // Main pulse length and the phase since the last main rise in this run.
    always_ff @(posedge core_clk_in) begin
        on_q <= main_gate_out ? on_q + 1 : 0;
        since_q <= (!running_out || $rose(main_gate_out)) ? 0 : since_q + 1;
        vld_q <= running_out && (vld_q || $rose(main_gate_out));
    end
    // Enable must have been steady, since a falling enable may cut a pulse.
    sequence s_en_steady;
        enable_in && $past(enable_in, 4);
    endsequence
    sequence s_idle;
        !running_out ##1 !running_out;
    endsequence
    AST_MIN_ON: assert property ($fell(main_gate_out) ##0 s_en_steady |-> on_q >= MIN_ON_CYC)
        else $error("main gate pulse shorter than the least on-time");
    AST_IDLE_OFF: assert property (s_idle |-> !main_gate_out && !color_gate_out)
        else $error("gate active while stopped");
    // Two sync flops, the run flop and the running flop put four samples between pin and port.
    AST_RUN_ON: assert property (enable_in [*4] |=> running_out)
        else $error("run state late after enable");
    AST_RUN_OFF: assert property (!enable_in [*4] |=> !running_out)
        else $error("run state kept after enable low");
    if (!PIN_VARIANT) begin : g_reg
        AST_PERIOD: assert property ($rose(main_gate_out) && vld_q |->
            since_q % PERIOD_CYC == PERIOD_CYC - 1)
            else $error("main rise off the period grid");
        AST_PHASE: assert property ($rose(color_gate_out) && vld_q |->
            since_q % PERIOD_CYC == PERIOD_CYC / 2 - 1)
            else $error("color rise not half a period from main");
        AST_RELOAD: assert property ($rose(running_out) |->
            ##[1:4] (main_gate_out && color_gate_out))
            else $error("codes not reloaded to full on");
    end else begin : g_pin
        // A start inside an input pulse is stretched to the least on-time, so skip that span.
        AST_PIN_MAIN: assert property (running_out && $past(running_out, 50) &&
            $past(main_dim_in, 3) == $past(main_dim_in, 4) |->
            main_gate_out == $past(main_dim_in, 3))
            else $error("main gate does not follow its input");
        AST_PIN_COLOR: assert property (running_out && $past(color_dim_in, 3) ==
            $past(color_dim_in, 4) |-> color_gate_out == $past(color_dim_in, 3))
            else $error("color gate does not follow its input");
    end
endmodule // dsd_dim_chk
`default_nettype wire

/* test/dsd_src_model.sv */
// Behavioural dimming source driving both dimming input pins.
`default_nettype none
module dsd_src_model (
    input  wire logic        core_clk_in,
    input  wire logic [16:0] main_hi_in,
    input  wire logic [16:0] color_hi_in,
    output logic             main_dim_out = 1'b0,
    output logic             color_dim_out = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MAIN_PER  = 1000;
    localparam int COLOR_PER = 40000;
    int          mc = 0;
    int          cc = 0;
    logic [16:0] mh = 17'h00000;
    logic [16:0] ch = 17'h00000;
    // Free-running periods; a new high time is taken only at a period start, so a change
    // never leaves a runt pulse that the main gate would stretch.
    always @(posedge core_clk_in) begin
        mc <= (mc == MAIN_PER - 1) ? 0 : mc + 1;
        cc <= (cc == COLOR_PER - 1) ? 0 : cc + 1;
        if (mc == 0) begin
            mh <= main_hi_in;
            main_dim_out <= main_hi_in != 17'h00000;
        end else begin
            main_dim_out <= mc < mh;
        end
        if (cc == 0) begin
            ch <= color_hi_in;
            color_dim_out <= color_hi_in != 17'h00000;
        end else begin
            color_dim_out <= cc < ch;
        end
    end
endmodule // dsd_src_model
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the dimming block in both build variants.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import dsd_pkg::*;
    localparam int P = 200;
    logic clk = 0, rst_n = 0, en = 0, wr = 0, md, cd, mg, cg, run, pmg, pcg;
    logic [1:0] sel = 0;
    logic [7:0] dat = 0;
    logic [16:0] mhi = 17'h00064, chi = 17'h00064;
    int n_errors = 0, cmp_count = 0, h[4];
    dsd_dimming #(.PIN_VARIANT(1'b0), .PERIOD_CYC(P), .MIN_ON_CYC(MAIN_MIN_ON_CYC)) uut (
        .core_clk_in(clk), .rst_n_in(rst_n), .enable_in(en), .main_dim_in(md),
        .color_dim_in(cd), .duty_wr_in(wr), .duty_sel_in(sel), .duty_data_in(dat),
        .main_gate_out(mg), .color_gate_out(cg), .running_out(run));
    dsd_dimming #(.PIN_VARIANT(1'b1), .PERIOD_CYC(P), .MIN_ON_CYC(MAIN_MIN_ON_CYC)) uut_pin (
        .core_clk_in(clk), .rst_n_in(rst_n), .enable_in(en), .main_dim_in(md),
        .color_dim_in(cd), .duty_wr_in(wr), .duty_sel_in(sel), .duty_data_in(dat),
        .main_gate_out(pmg), .color_gate_out(pcg), .running_out());
    dsd_src_model src (.core_clk_in(clk), .main_hi_in(mhi), .color_hi_in(chi),
        .main_dim_out(md), .color_dim_out(cd));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Expected on-cycles per period; only the main string gets the stretch.
    function automatic int eon(input logic [11:0] c, input bit mn);
        int on;
        on = (int'(c) * P) >> 12;
        if (c == DUTY_FULL) return P;
        if (mn && on > 0 && on < MAIN_MIN_ON_CYC) return MAIN_MIN_ON_CYC;
        return on;
    endfunction
    // Back-to-back byte writes, high then low, main then color.
    task automatic setc(input logic [11:0] m, input logic [11:0] c);
        logic [7:0] b[4];
        b = '{m[11:4], {4'h0, m[3:0]}, c[11:4], {4'h0, c[3:0]}};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            wr <= 1'b1;
            sel <= i[1:0];
            dat <= b[i];
        end
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // High cycles of all four gates over n cycles, sampled at the falling edge.
    task automatic win(input int n);
        h = '{default: 0};
        repeat (n) begin
            @(negedge clk);
            h[0] += mg; h[1] += cg; h[2] += pmg; h[3] += pcg;
        end
    endtask
    task automatic duty(input logic [11:0] m, input logic [11:0] c);
        setc(m, c);
        repeat (2 * P) @(posedge clk);
        win(P);
        chk(h[0], eon(m, 1));
        chk(h[1], eon(c, 0));
        $display("duty test %h %h done", m, c);
    endtask
    task automatic full_check();
        repeat (3 * P) @(posedge clk);
        win(P);
        chk(h[0], P);
        chk(h[1], P);
        $display("reload test done");
    endtask
    initial begin
        forever #25 clk = ~clk;
    end
    // The run is a few tens of thousands of cycles; twice that means a hang.
    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        conclude();
    end
    initial begin
        void'($urandom(32'h6E4E9BA1));
        // Source high times are fixed before the first source period so every period is whole.
        mhi <= 17'(50 + $urandom_range(900));
        chi <= 17'(40 + $urandom_range(39900));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        en <= 1'b1;
        full_check();
        duty(12'h015, 12'h015);
        duty(12'h000, 12'hFFE);
        duty(12'h800, 12'h001);
        repeat (3) duty(12'($urandom), 12'($urandom));
        // Writes while stopped are lost to the reload on the next enable.
        @(posedge clk);
        en <= 1'b0;
        setc(12'h100, 12'h100);
        repeat (6) @(negedge clk);
        chk(run, 1'b0);
        chk({mg, cg, pmg, pcg}, 4'h0);
        @(posedge clk);
        en <= 1'b1;
        full_check();
        @(posedge clk);
        repeat (10) @(posedge clk);
        win(40000);
        chk(h[2], 40 * mhi);
        chk(h[3], chi);
        $display("pin variant test done");
        conclude();
    end
endmodule // tb_top
bind dsd_dimming dsd_dim_chk #(.PIN_VARIANT(PIN_VARIANT), .PERIOD_CYC(PERIOD_CYC),
    .MIN_ON_CYC(MIN_ON_CYC)) chk (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .enable_in(enable_in), .main_dim_in(main_dim_in), .color_dim_in(color_dim_in),
    .duty_wr_in(duty_wr_in), .duty_sel_in(duty_sel_in), .duty_data_in(duty_data_in),
    .main_gate_out(main_gate_out), .color_gate_out(color_gate_out),
    .running_out(running_out));
`default_nettype wire
